// *** i2c_seq_pkg.sv ***
package i2c_seq_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [1:0] ADDR_BUF = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_CTRL = 2'h2;
  localparam logic [1:0] ADDR_RELOAD = 2'h3;
  localparam int ST_BF = 0;
  localparam int ST_STOP = 1;
  localparam int ST_START = 2;
  localparam int ST_ACK = 3;
  localparam int ST_EVENT = 4;
  localparam int ST_WRITE_COLLISION_FLAG = 5;
  localparam int ST_OVF = 6;
  localparam int ST_COLL = 7;
  localparam int CT_EN = 0;
  localparam int CT_RCV = 1;
  localparam int CT_ACKSEQ = 2;
  localparam int CT_STOPSEQ = 3;
  localparam int CT_ACK_DATA_BIT = 4;
  localparam int CT_IE = 5;
  localparam logic [6:0] RELOAD_RST = 7'h04;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int INSTR_NS = 40;
  localparam int INSTR_CLKS = (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CLKS = (INSTR_CLKS / 2 < 1) ? 1 : INSTR_CLKS / 2;
  localparam logic [1:0] TICK_LAST = 2'(TICK_CLKS - 1);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_LOW = 4'h1,
    ST_REL = 4'h3,
    ST_HIGH = 4'h2,
    ST_STOP_SDA = 4'h6,
    ST_STOP_LOW = 4'h7,
    ST_STOP_REL = 4'h5,
    ST_STOP_HIGH = 4'h4,
    ST_STOP_SDAH = 4'hc,
    ST_STOP_END = 4'hd
  } state_t;

  typedef enum logic [1:0] {
    MODE_TX = 2'h0,
    MODE_RX = 2'h1,
    MODE_ACK = 2'h3
  } mode_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } lines_t;

endpackage

// *** i2c_master_byte_sequencer.sv ***
`timescale 1ns/1ps
module i2c_master_byte_sequencer
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Bus lines, open drain, enables active low.
  input wire i2c_seq_pkg::lines_t linesIn,
  output i2c_seq_pkg::lines_t linesOut,
  output i2c_seq_pkg::lines_t linesOe_n,
  // Sleep and wake.
  input wire logic sleepMode,
  output logic wakeRequest
);
  import i2c_seq_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic sclMeta_r, sclSync_r, sclPrev_r, sdaMeta_r, sdaSync_r, sdaPrev_r;
  logic startDet, stopDet;
  logic bufWr, bufRd, statWr, ctrlWr, reloadWr, busy, bufWrOk;
  logic rcvReq, ackReq, stopReq;
  logic [1:0] tickCnt_r;
  logic tick, brgRun, brgDone;
  logic [6:0] brgCnt_r, reload_r;
  state_t state_r;
  mode_t mode_r;
  logic [3:0] bitCnt_r;
  logic [7:0] bitShift_r, transferBuffer_r, regRdata_r;
  logic sclLow_r, sdaLow_r, brgLoad_r;
  logic rcvEn_r, ack_sequence_enable_r, stopEn_r;
  logic portEn_r, intEn_r, ackData_r;
  logic bufferFull_r, ackStatus_r, eventFlag_r, writeCollision_r;
  logic receiveOverflow_r, collision_r, startSeen_r, stopSeen_r;
  logic wakeRequest_r;
  logic hiDone, txBit7End, txByteEnd, rxByteEnd, ackEnd, stopEnd;
  logic collDet;

  // ****************************************************************
  // Pin synchronisers and condition detection
  // ****************************************************************
  // Idle bus is high, so the chain resets high to avoid a false start.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
      sclPrev_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else
    begin
      sclMeta_r <= linesIn.scl;
      sclSync_r <= sclMeta_r;
      sclPrev_r <= sclSync_r;
      sdaMeta_r <= linesIn.sda;
      sdaSync_r <= sdaMeta_r;
      sdaPrev_r <= sdaSync_r;
    end
  end

  // SDA edges while SCL stays high are START and STOP.
  assign startDet = sclSync_r && sclPrev_r && sdaPrev_r && !sdaSync_r;
  assign stopDet = sclSync_r && sclPrev_r && !sdaPrev_r && sdaSync_r;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // The port does not queue commands: anything but idle counts as busy.
  always_comb
  begin
    bufWr = 1'b0;
    statWr = 1'b0;
    ctrlWr = 1'b0;
    reloadWr = 1'b0;
    if (regWrite && regAddr == ADDR_BUF)
      bufWr = 1'b1;
    else if (regWrite && regAddr == ADDR_STAT)
      statWr = 1'b1;
    else if (regWrite && regAddr == ADDR_CTRL)
      ctrlWr = 1'b1;
    else if (regWrite && regAddr == ADDR_RELOAD)
      reloadWr = 1'b1;
  end

  assign bufRd = regRead && regAddr == ADDR_BUF;
  assign busy = state_r != ST_IDLE;
  assign bufWrOk = bufWr && !busy && portEn_r;
  assign rcvReq = ctrlWr && regWdata[CT_RCV] && !busy && portEn_r;
  assign ackReq = ctrlWr && regWdata[CT_ACKSEQ] && !busy && portEn_r;
  assign stopReq = ctrlWr && regWdata[CT_STOPSEQ] && !busy && portEn_r;

  // ****************************************************************
  // Rate generator
  // ****************************************************************
  // Two decrements per instruction cycle.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tickCnt_r <= 2'h0;
    else if (tickCnt_r == TICK_LAST)
      tickCnt_r <= 2'h0;
    else
      tickCnt_r <= tickCnt_r + 2'h1;
  end

  assign tick = tickCnt_r == TICK_LAST;
  assign brgRun = state_r == ST_LOW || state_r == ST_HIGH ||
                  state_r == ST_STOP_LOW || state_r == ST_STOP_HIGH ||
                  state_r == ST_STOP_END;
  // A load pending this cycle masks the stale zero of the last count.
  assign brgDone = brgRun && !brgLoad_r && brgCnt_r == 7'h00;

  // Counts down to zero and stops there until the next reload.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      brgCnt_r <= 7'h00;
    else if (brgLoad_r)
      brgCnt_r <= reload_r;
    else if (brgRun && tick && brgCnt_r != 7'h00)
      brgCnt_r <= brgCnt_r - 7'h01;
  end

  // ****************************************************************
  // Sequencer events
  // ****************************************************************
  assign hiDone = state_r == ST_HIGH && brgDone;
  assign txBit7End = hiDone && mode_r == MODE_TX && bitCnt_r == BIT_LAST;
  assign txByteEnd = hiDone && mode_r == MODE_TX && bitCnt_r == BIT_ACK;
  assign rxByteEnd = hiDone && mode_r == MODE_RX && bitCnt_r == BIT_LAST;
  assign ackEnd = hiDone && mode_r == MODE_ACK;
  assign stopEnd = state_r == ST_STOP_END && brgDone;
  // Released SDA read low while SCL is high means another master won.
  assign collDet = (state_r == ST_HIGH && !sdaLow_r && !sdaSync_r &&
                    ((mode_r == MODE_TX && bitCnt_r != BIT_ACK) ||
                     mode_r == MODE_ACK)) ||
                   (state_r == ST_STOP_HIGH && !sclSync_r);

  // ****************************************************************
  // Byte sequencer
  // ****************************************************************
  // Idle leaves SCL low after a byte, so the next command starts at once.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      mode_r <= MODE_TX;
      bitCnt_r <= 4'h0;
      bitShift_r <= 8'h00;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      brgLoad_r <= 1'b0;
      rcvEn_r <= 1'b0;
      ack_sequence_enable_r <= 1'b0;
      stopEn_r <= 1'b0;
    end
    else
    begin
      brgLoad_r <= 1'b0;
      if (!portEn_r || collDet)
      begin
        state_r <= ST_IDLE;
        sclLow_r <= 1'b0;
        sdaLow_r <= 1'b0;
        rcvEn_r <= 1'b0;
        ack_sequence_enable_r <= 1'b0;
        stopEn_r <= 1'b0;
      end
      else
        case (state_r)
          ST_IDLE:
            if (bufWrOk)
            begin
              bitShift_r <= regWdata;
              mode_r <= MODE_TX;
              bitCnt_r <= 4'h0;
              sclLow_r <= 1'b1;
              brgLoad_r <= 1'b1;
              state_r <= ST_LOW;
            end
            else if (rcvReq)
            begin
              mode_r <= MODE_RX;
              rcvEn_r <= 1'b1;
              bitCnt_r <= 4'h0;
              sclLow_r <= 1'b1;
              sdaLow_r <= 1'b0;
              brgLoad_r <= 1'b1;
              state_r <= ST_LOW;
            end
            else if (ackReq)
            begin
              mode_r <= MODE_ACK;
              ack_sequence_enable_r <= 1'b1;
              sclLow_r <= 1'b1;
              sdaLow_r <= !regWdata[CT_ACK_DATA_BIT];
              brgLoad_r <= 1'b1;
              state_r <= ST_LOW;
            end
            else if (stopReq)
            begin
              stopEn_r <= 1'b1;
              sclLow_r <= 1'b1;
              sdaLow_r <= 1'b1;
              state_r <= ST_STOP_SDA;
            end
          ST_LOW:
          begin
            // Transmit data moves one clock after SCL fell, never with it.
            if (brgLoad_r && mode_r == MODE_TX)
              sdaLow_r <= bitCnt_r != BIT_ACK && !bitShift_r[7];
            if (brgDone)
            begin
              sclLow_r <= 1'b0;
              state_r <= ST_REL;
            end
          end
          ST_REL:
            if (sclSync_r)
            begin
              brgLoad_r <= 1'b1;
              state_r <= ST_HIGH;
            end
          ST_HIGH:
            if (brgDone)
            begin
              sclLow_r <= 1'b1;
              if (mode_r == MODE_TX)
              begin
                if (bitCnt_r == BIT_ACK)
                  state_r <= ST_IDLE;
                else
                begin
                  bitShift_r <= {bitShift_r[6:0], 1'b0};
                  bitCnt_r <= bitCnt_r + 4'h1;
                  brgLoad_r <= 1'b1;
                  state_r <= ST_LOW;
                end
              end
              else if (mode_r == MODE_RX)
              begin
                bitShift_r <= {bitShift_r[6:0], sdaSync_r};
                if (bitCnt_r == BIT_LAST)
                begin
                  rcvEn_r <= 1'b0;
                  state_r <= ST_IDLE;
                end
                else
                begin
                  bitCnt_r <= bitCnt_r + 4'h1;
                  brgLoad_r <= 1'b1;
                  state_r <= ST_LOW;
                end
              end
              else
              begin
                ack_sequence_enable_r <= 1'b0;
                state_r <= ST_IDLE;
              end
            end
          ST_STOP_SDA:
            if (!sdaSync_r)
            begin
              brgLoad_r <= 1'b1;
              state_r <= ST_STOP_LOW;
            end
          ST_STOP_LOW:
            if (brgDone)
            begin
              sclLow_r <= 1'b0;
              state_r <= ST_STOP_REL;
            end
          ST_STOP_REL:
            if (sclSync_r)
            begin
              brgLoad_r <= 1'b1;
              state_r <= ST_STOP_HIGH;
            end
          ST_STOP_HIGH:
            if (brgDone)
            begin
              sdaLow_r <= 1'b0;
              state_r <= ST_STOP_SDAH;
            end
          ST_STOP_SDAH:
            if (sdaSync_r && sclSync_r)
            begin
              brgLoad_r <= 1'b1;
              state_r <= ST_STOP_END;
            end
          ST_STOP_END:
            if (brgDone)
            begin
              stopEn_r <= 1'b0;
              state_r <= ST_IDLE;
            end
          default:
            state_r <= ST_IDLE;
        endcase
    end
  end

  bufLoad_a: assert property (bufWrOk |=> bufferFull_r && state_r == ST_LOW)
    else $error("buffer write did not start a byte");
  bitEight_a: assert property (txBit7End && portEn_r |=> !bufferFull_r ##1 !sdaLow_r)
    else $error("SDA not released for acknowledge");
  relHold_a: assert property (state_r == ST_REL && !sclSync_r && portEn_r
                              |=> state_r == ST_REL && $stable(brgCnt_r))
    else $error("rate generator ran while SCL held low");
  idleHalt_a: assert property (state_r == ST_IDLE |=> $stable(brgCnt_r))
    else $error("rate generator ran in idle");
  rcvIgnore_a: assert property (ctrlWr && regWdata[CT_RCV] && busy && !rcvEn_r
                                |=> !rcvEn_r)
    else $error("receive enable taken while busy");
  collIdle_a: assert property (collDet |=> state_r == ST_IDLE && collision_r
                               && !sclLow_r && !sdaLow_r)
    else $error("collision did not idle the port");

  // ****************************************************************
  // Transfer buffer and status flags
  // ****************************************************************
  // A refused write leaves the buffer exactly as it was.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      transferBuffer_r <= 8'h00;
    else if (rxByteEnd)
      transferBuffer_r <= {bitShift_r[6:0], sdaSync_r};
    else if (bufWrOk)
      transferBuffer_r <= regWdata;
  end

  // Clears come first so a same-cycle set always wins.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bufferFull_r <= 1'b0;
    else
    begin
      if (bufRd || txBit7End || collDet)
        bufferFull_r <= 1'b0;
      if (bufWrOk || rxByteEnd)
        bufferFull_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ackStatus_r <= 1'b0;
    else if (txByteEnd)
      ackStatus_r <= sdaSync_r;
  end

  // Sticky flags, cleared by writing a one to their status bit.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eventFlag_r <= 1'b0;
      writeCollision_r <= 1'b0;
      receiveOverflow_r <= 1'b0;
      collision_r <= 1'b0;
    end
    else
    begin
      if (statWr && regWdata[ST_EVENT])
        eventFlag_r <= 1'b0;
      if (statWr && regWdata[ST_WRITE_COLLISION_FLAG])
        writeCollision_r <= 1'b0;
      if (statWr && regWdata[ST_OVF])
        receiveOverflow_r <= 1'b0;
      if (statWr && regWdata[ST_COLL])
        collision_r <= 1'b0;
      if (txByteEnd || rxByteEnd || stopEnd)
        eventFlag_r <= 1'b1;
      if (stopDet && startSeen_r)
        eventFlag_r <= 1'b1;
      if (bufWr && busy)
        writeCollision_r <= 1'b1;
      if (rxByteEnd && bufferFull_r)
        receiveOverflow_r <= 1'b1;
      if (collDet)
        collision_r <= 1'b1;
    end
  end

  ackSample_a: assert property (txByteEnd && portEn_r |=> ackStatus_r ==
                                $past(sdaSync_r) && eventFlag_r &&
                                state_r == ST_IDLE && sclLow_r)
    else $error("acknowledge not sampled at ninth clock");
  wcolSet_a: assert property (bufWr && busy && !rxByteEnd
                              |=> writeCollision_r && $stable(transferBuffer_r))
    else $error("write collision not flagged");
  overflow_a: assert property (rxByteEnd && bufferFull_r
                               |=> receiveOverflow_r && bufferFull_r)
    else $error("receive overflow missed");
  stopEnd_a: assert property (stopEnd && portEn_r |=> !stopEn_r && eventFlag_r
                              && state_r == ST_IDLE)
    else $error("stop sequence did not finish");

  // ****************************************************************
  // Bus monitor
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      startSeen_r <= 1'b0;
      stopSeen_r <= 1'b0;
    end
    else if (!portEn_r)
    begin
      startSeen_r <= 1'b0;
      stopSeen_r <= 1'b0;
    end
    else if (startDet)
    begin
      startSeen_r <= 1'b1;
      stopSeen_r <= 1'b0;
    end
    else if (stopDet || (state_r == ST_STOP_SDAH && sdaSync_r && sclSync_r))
    begin
      startSeen_r <= 1'b0;
      stopSeen_r <= 1'b1;
    end
  end

  disClear_a: assert property (!portEn_r |=> !startSeen_r && !stopSeen_r)
    else $error("bus flags survive disable");

  // ****************************************************************
  // Control, reload and wake
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      portEn_r <= 1'b0;
      intEn_r <= 1'b0;
      ackData_r <= 1'b0;
    end
    else if (ctrlWr)
    begin
      portEn_r <= regWdata[CT_EN];
      intEn_r <= regWdata[CT_IE];
      ackData_r <= regWdata[CT_ACK_DATA_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reload_r <= RELOAD_RST;
    else if (reloadWr)
      reload_r <= regWdata[6:0];
  end

  // The sequencer runs on during sleep; only the wake request needs it.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wakeRequest_r <= 1'b0;
    else
      wakeRequest_r <= sleepMode && intEn_r && eventFlag_r;
  end

  // ****************************************************************
  // Read data and pins
  // ****************************************************************
  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata_r <= 8'h00;
    else if (!regRead)
      regRdata_r <= 8'h00;
    else if (regAddr == ADDR_BUF)
      regRdata_r <= transferBuffer_r;
    else if (regAddr == ADDR_STAT)
      regRdata_r <= {collision_r, receiveOverflow_r, writeCollision_r,
                     eventFlag_r, ackStatus_r, startSeen_r, stopSeen_r,
                     bufferFull_r};
    else if (regAddr == ADDR_CTRL)
      regRdata_r <= {2'h0, intEn_r, ackData_r, stopEn_r, ack_sequence_enable_r, rcvEn_r,
                     portEn_r};
    else
      regRdata_r <= {1'b0, reload_r};
  end

  assign regRdata = regRdata_r;
  assign wakeRequest = wakeRequest_r;
  assign linesOut = '0;
  assign linesOe_n = '{scl: !sclLow_r, sda: !sdaLow_r};

  txByte_c: cover property (txByteEnd);
  rxByte_c: cover property (rxByteEnd);
  ackSeq_c: cover property (ackEnd);
  stopSeq_c: cover property (stopEnd);
  lostArb_c: cover property (collDet);

endmodule

// *** bus_slave_model.sv ***
`timescale 1ns/1ps
// ****************
// Far-side slave
// ****************
module bus_slave_model
(
  // Bus clock level.
  input wire logic scl,
  // Bench controls.
  input wire logic restart,
  input wire logic rxMode,
  input wire logic ackOn,
  input wire logic [7:0] rxByte,
  // High pulls SDA low; released SDA floats to the pull-up.
  output logic sdaPull
);
  logic [3:0] cnt;
  // Rising SCL edges seen since the last restart.
  always @(posedge scl or posedge restart)
    if (restart)
      cnt <= 4'h0;
    else
      cnt <= cnt + 4'h1;
  // Apart from a restart, SDA only moves while SCL is low, so the master samples settled bits.
  always @(negedge scl or posedge restart)
    if (restart)
      sdaPull <= rxMode & ~rxByte[7];
    else if (rxMode)
      sdaPull <= (cnt < 4'h8) & ~rxByte[3'h7 - cnt[2:0]];
    else
      sdaPull <= (cnt == 4'h8) & ackOn; // Acknowledge slot only.
endmodule

// *** tb_i2c_master_byte_sequencer.sv ***
`timescale 1ns/1ps
module tb_i2c_master_byte_sequencer;
  import i2c_seq_pkg::*;
  logic clk, reset_n, regWrite, regRead, sleepMode, wakeRequest;
  logic restart, rxMode, ackOn, sdaPull, sclW, sdaW;
  logic [1:0] regAddr;
  logic [7:0] regWdata, regRdata, rxByte, s;
  logic [8:0] mon;
  lines_t linesOe_n, linesOut;
  int fail_count, samples_checked;
  // ****************
  // Wiring
  // ****************
  // Open-drain lines with pull-ups; a low from any party wins.
  assign sclW = linesOe_n.scl;
  assign sdaW = linesOe_n.sda & ~sdaPull;
  i2c_master_byte_sequencer i2c_master_byte_sequencer_inst (.clk(clk),
    .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .linesIn({sclW, sdaW}), .linesOut(linesOut), .linesOe_n(linesOe_n),
    .sleepMode(sleepMode), .wakeRequest(wakeRequest));
  bus_slave_model bus_slave_model_inst (.scl(sclW), .restart(restart),
    .rxMode(rxMode), .ackOn(ackOn), .rxByte(rxByte), .sdaPull(sdaPull));
  // Clock and a shift of every bit seen at a rising SCL edge.
  always #5 clk = ~clk;
  always @(posedge sclW) mon <= {mon[7:0], sdaW};
  // ****************
  // Tasks
  // ****************
  task chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rd(input logic [1:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdata;
    @(posedge clk);
    #1;
  endtask
  // Polling is bounded so a stuck flag shows as a mismatch.
  task wait_bit(input logic [1:0] a, input int b, input logic v);
    int n;
    n = 0;
    rd(a, s);
    while (s[b] !== v && n < 3000)
    begin
      rd(a, s);
      n++;
    end
    chk({8'h0, s[b]}, {8'h0, v});
  endtask
  // Mode settles a cycle before the restart pulse samples it.
  task kick(input logic rx);
    rxMode <= rx;
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    #1;
  endtask
  task tx_pair;
    wr(ADDR_BUF, 8'ha5);
    rd(ADDR_STAT, s);
    chk({8'h0, s[ST_BF]}, 9'h1);
    wr(ADDR_BUF, 8'h3c);
    wait_bit(ADDR_STAT, ST_EVENT, 1'b1);
    chk(mon, 9'h14a);
    chk({4'h0, s[ST_WRITE_COLLISION_FLAG], s[ST_ACK], s[ST_BF], linesOe_n}, 9'h11);
    rd(ADDR_BUF, s);
    chk({1'b0, s}, 9'h0a5);
    wr(ADDR_STAT, 8'hf0);
    ackOn <= 1'b0;
    sleepMode <= 1'b1;
    kick(1'b0);
    wr(ADDR_CTRL, 8'h21);
    wr(ADDR_BUF, 8'h5a);
    wait_bit(ADDR_STAT, ST_EVENT, 1'b1);
    chk({s[ST_ACK], mon[8:1]}, 9'h15a);
    chk({8'h0, wakeRequest}, 9'h1);
    wr(ADDR_STAT, 8'hf0);
    sleepMode <= 1'b0;
  endtask
  task rx_pair;
    rxByte <= 8'h3c;
    kick(1'b1);
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_BUF, 8'h11);
    wait_bit(ADDR_STAT, ST_EVENT, 1'b1);
    chk({6'h0, s[ST_WRITE_COLLISION_FLAG], s[ST_BF], linesOe_n.scl}, 9'h6);
    wr(ADDR_STAT, 8'hf0);
    kick(1'b1);
    wr(ADDR_CTRL, 8'h03);
    wait_bit(ADDR_STAT, ST_OVF, 1'b1);
    rd(ADDR_BUF, s);
    chk({1'b0, s}, 9'h03c);
    rd(ADDR_STAT, s);
    chk({8'h0, s[ST_BF]}, 9'h0);
    wr(ADDR_STAT, 8'hf0);
  endtask
  // Not-acknowledge then acknowledge, then a stop on a quiet bus.
  task ack_stop;
    for (int i = 1; i >= 0; i--)
    begin
      wr(ADDR_CTRL, {3'h0, i[0], 4'h5});
      wait_bit(ADDR_CTRL, CT_ACKSEQ, 1'b0);
      chk({8'h0, mon[0]}, {8'h0, i[0]});
    end
    wr(ADDR_CTRL, 8'h09);
    wait_bit(ADDR_CTRL, CT_STOPSEQ, 1'b0);
    rd(ADDR_STAT, s);
    chk({5'h0, s[ST_EVENT], s[ST_STOP], linesOe_n}, 9'hf);
  endtask
  // The slave holds SDA low under a released one; then disable the port.
  task collide;
    rxByte <= 8'h00;
    kick(1'b1);
    wr(ADDR_BUF, 8'h80);
    wait_bit(ADDR_STAT, ST_COLL, 1'b1);
    chk({6'h0, s[ST_BF], linesOe_n}, 9'h3);
    kick(1'b0);
    wait_bit(ADDR_STAT, ST_STOP, 1'b1);
    chk({8'h0, s[ST_EVENT]}, 9'h1);
    wr(ADDR_CTRL, 8'h00);
    @(posedge clk);
    #1;
    rd(ADDR_STAT, s);
    chk({7'h0, s[ST_START], s[ST_STOP]}, 9'h0);
    chk({7'h0, linesOut}, 9'h0);
  endtask
  task print_verdict;
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    {clk, reset_n, regWrite, regRead, sleepMode, rxMode} = 6'h0;
    {regAddr, regWdata, rxByte, mon} = 27'h0;
    {restart, ackOn} = 2'h3;
    fail_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    restart <= 1'b0;
    @(posedge clk);
    #1;
    rd(ADDR_RELOAD, s);
    chk({1'b0, s}, 9'h004);
    wr(ADDR_RELOAD, 8'h01);
    wr(ADDR_CTRL, 8'h01);
    tx_pair();
    rx_pair();
    ack_stop();
    collide();
    print_verdict();
  end
  // Whole run needs well under 20000 cycles.
  initial
  begin
    #400000;
    fail_count++;
    print_verdict();
  end
endmodule
